// ==== hw/and_accum_file_instr.v ====
// Purpose: Decode and execute the AND-accumulator-with-file instruction
// Assumes: Instruction and host ports come from logic on core_clk
// Notes:   One instruction cycle is four core clocks, fixed for both
//          destinations; host file access only while the block is idle.
//          Host ports stand in for the rest of the core: they preload
//          the accumulator and reach the file between instructions.
`timescale 1ns/100ps
`include "and_accum_file_map.vh"
module and_accum_file_instr
#(
  parameter DW    = `DATA_W,
  parameter AW    = `IDX_W,
  parameter DEPTH = 128
)
(
  input  wire          core_clk,
  input  wire          rstn,
  input  wire          clk_en,
  input  wire          instr_valid,
  input  wire [13:0]   instr_word,
  output wire          instr_ready,
  output reg           unknown_op,
  output reg           exec_done,
  output reg  [DW-1:0] accum,
  output reg           zero_flag,
  input  wire          acc_load,
  input  wire [DW-1:0] acc_wdata,
  input  wire          host_wr,
  input  wire          host_rd,
  input  wire [AW-1:0] host_addr,
  input  wire [DW-1:0] host_wdata,
  output wire [DW-1:0] host_rdata,
  output wire          busy
);

  // Phase codes of one instruction cycle
  localparam PH_IDLE = `PH_IDLE;
  localparam PH_READ = `PH_READ;
  localparam PH_CALC = `PH_CALC;
  localparam PH_WB   = `PH_WB;

  reg  [`PH_W-1:0] phase_reg;
  reg  [`PH_W-1:0] phase_next;
  reg              dest_reg;
  reg  [AW-1:0]    idx_reg;
  reg  [DW-1:0]    result_reg;
  wire             take;
  reg              ram_wr;
  reg              ram_rd;
  reg  [AW-1:0]    ram_addr;
  reg  [DW-1:0]    ram_wdata;
  wire [DW-1:0]    ram_rdata;
  wire [DW-1:0]    and_value;
  wire             dest_field;
  wire [AW-1:0]    idx_field;

  // True when the word carries this block's opcode
  function is_and_file;
    input [13:0] word;
    begin
      is_and_file = (word[`OPC_HI:`OPC_LO] == `OPC_AND_FILE);
    end
  endfunction

  // All-zero test of a data byte, as the zero flag wants it
  function is_zero;
    input [DW-1:0] value;
    begin
      is_zero = (value == `DATA_ZERO);
    end
  endfunction

  // Operand fields of the offered word; only latched when it is taken
  assign dest_field = instr_word[`DEST_BIT];
  assign idx_field  = instr_word[`IDX_HI:`IDX_LO];

  // Only accept while idle, so a new word never cuts an old one short
  assign instr_ready = (phase_reg == PH_IDLE);
  assign busy        = (phase_reg != PH_IDLE);
  assign take        = clk_en && instr_valid && instr_ready
                       && is_and_file(instr_word);

  // Phase sequencer: same four phases whatever the destination
  always @*
  begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE:
      begin
        if (take)
          phase_next = PH_READ;
      end
      PH_READ: phase_next = PH_CALC;
      PH_CALC: phase_next = PH_WB;
      PH_WB:   phase_next = PH_IDLE;
      default: phase_next = PH_IDLE;
    endcase
  end

  // Phase register; clk_en low holds an instruction where it stands
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      phase_reg <= PH_IDLE;
    else if (clk_en)
      phase_reg <= phase_next;
  end

  // Latch destination and file index from the taken word,
  // so the offered word may change once it has been taken
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dest_reg <= `DEST_RST;
      idx_reg  <= `IDX_RST;
    end
    else if (take)
    begin
      dest_reg <= dest_field;
      idx_reg  <= idx_field;
    end
  end

  // Flag words that are offered but are not this instruction
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      unknown_op <= `PULSE_RST;
    else if (clk_en)
      unknown_op <= instr_valid && instr_ready
                    && !is_and_file(instr_word);
  end

  // File port owner: the instruction while busy, the host while idle.
  // Host strobes are dropped, not queued, while busy; a queue would let
  // a host write land after the instruction has read the old byte
  always @*
  begin
    ram_rd    = host_rd;
    ram_wr    = host_wr;
    ram_addr  = host_addr;
    ram_wdata = host_wdata;
    if (busy)
    begin
      ram_rd    = (phase_reg == PH_READ);
      ram_wr    = (phase_reg == PH_WB) && dest_reg;
      ram_addr  = idx_reg;
      ram_wdata = result_reg;
    end
  end

  // Host read data is the file's own read register
  assign host_rdata = ram_rdata;

  // One-port file; a read or a write takes one core clock
  file_ram
  #(
    .DW    (DW),
    .AW    (AW),
    .DEPTH (DEPTH)
  )
  u_file
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .wr_en    (ram_wr),
    .rd_en    (ram_rd),
    .addr     (ram_addr),
    .wdata    (ram_wdata),
    .rdata    (ram_rdata)
  );

  // Bitwise AND of accumulator with the file byte read last phase
  assign and_value = accum & ram_rdata;

  // Hold the result so the file write sees a stable value,
  // and the AND path stays off the write-back timing path
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      result_reg <= `DATA_ZERO;
    else if (clk_en && phase_reg == PH_CALC)
      result_reg <= and_value;
  end

  // Accumulator: written by the instruction only when destination is 0;
  // the host preload is ignored while busy so it cannot race the result
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      accum <= `ACC_RST;
    else if (clk_en)
    begin
      if (phase_reg == PH_WB && !dest_reg)
        accum <= result_reg;
      else if (!busy && acc_load)
        accum <= acc_wdata;
    end
  end

  // Zero flag is the only status bit this instruction touches;
  // the other status bits live outside and never see a write
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      zero_flag <= `ZERO_RST;
    else if (clk_en && phase_reg == PH_WB)
      zero_flag <= is_zero(result_reg);
  end

  // Completion pulse, issued in the same phase for both destinations,
  // so a caller never needs to know which way the result went
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      exec_done <= `PULSE_RST;
    else if (clk_en)
      exec_done <= (phase_reg == PH_WB);
  end

endmodule

// ==== inc/and_accum_file_map.vh ====
// Purpose: Constants for the AND-accumulator-with-file instruction block
// Assumes: 14-bit instruction words, 8-bit data, 128 file registers
// Notes:   Definitions only; included by bare name
// Notes on behaviour
// - Opcode 000101 in top six bits; d, index
// - Result is accumulator AND addressed file register
// - Destination bit 0 writes accumulator only
// - Destination bit 1 writes file register only
// - Only zero flag changes, set on zero result
// - One word, one instruction cycle either way
`ifndef AND_ACCUM_FILE_MAP_VH
`define AND_ACCUM_FILE_MAP_VH

// Instruction word layout
`define INSTR_W        14
`define OPC_HI         13
`define OPC_LO         8
`define OPC_AND_FILE   6'h05
`define DEST_BIT       7
`define IDX_HI         6
`define IDX_LO         0

// Data widths and reset values
`define DATA_W         8
`define IDX_W          7
`define ACC_RST        8'h00
`define ZERO_RST       1'h0
`define IDX_RST        7'h00
`define DEST_RST       1'h0
`define PULSE_RST      1'h0
`define DATA_ZERO      8'h00

// Phase counter of one instruction cycle
`define PH_W           2
`define PH_IDLE        2'h0
`define PH_READ        2'h1
`define PH_CALC        2'h2
`define PH_WB          2'h3

`endif

// ==== hw/file_ram.v ====
// Purpose: Data-memory file of the core, one port, registered read
// Assumes: One clock; clk_en low freezes array and read register
// Notes:   Array has no reset, as in a real register file
`timescale 1ns/100ps
module file_ram
#(
  parameter DW    = 8,
  parameter AW    = 7,
  parameter DEPTH = 128
)
(
  input  wire          core_clk,
  input  wire          rstn,
  input  wire          clk_en,
  input  wire          wr_en,
  input  wire          rd_en,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // Write port; no reset so it maps onto plain RAM
  always @(posedge core_clk)
  begin
    if (clk_en && wr_en)
      mem[addr] <= wdata;
  end

  // Read data comes out of a register, one clock after the address
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= {DW{1'b0}};
    else if (clk_en && rd_en)
      rdata <= mem[addr];
  end

endmodule

// ==== sim/and_accum_file_instr_props.sv ====
// Purpose: Port-level timing and result checks
// Assumes: clk_en does not fall while exec_done is high
// Notes:   File contents are not visible here; the bench reads them
`timescale 1ns/100ps
module and_accum_file_instr_props
(
  input wire        core_clk,
  input wire        rstn,
  input wire        clk_en,
  input wire        instr_valid,
  input wire [13:0] instr_word,
  input wire        instr_ready,
  input wire        unknown_op,
  input wire        exec_done,
  input wire [7:0]  accum,
  input wire        zero_flag,
  input wire        busy
);
  // Offer counts only while idle and enabled
  wire offer = clk_en && instr_valid && instr_ready;
  wire hit   = offer && instr_word[13:8] == 6'h05;
  wire to_w  = hit && !instr_word[7];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_TAKE: assert property (hit |=> busy && !instr_ready)
    else $error("word not taken");
  AST_DROP: assert property (offer && !hit |=> unknown_op && !busy)
    else $error("foreign word not dropped");
  AST_CYCLE: assert property (hit ##1 clk_en[*3] |=> exec_done)
    else $error("done late");
  AST_DONE: assert property (exec_done |-> !busy && $past(busy))
    else $error("done without busy");
  AST_PULSE: assert property (exec_done && clk_en |=> !exec_done)
    else $error("done too long");
  AST_KEEP: assert property (hit && instr_word[7]
    |=> $stable(accum)[*4])
    else $error("accumulator moved");
  AST_TO_W: assert property (to_w ##1 clk_en[*3]
    |=> (accum & ~$past(accum, 4)) == 8'h00)
    else $error("bits set by and");
  AST_ZERO: assert property (to_w ##1 clk_en[*3]
    |=> zero_flag == (accum == 8'h00))
    else $error("zero flag wrong");
  cover property (to_w);
  cover property (busy && !clk_en);
  cover property (hit && instr_word[7]);
  cover property (offer && !hit);
endmodule

bind and_accum_file_instr and_accum_file_instr_props i_props
(
  .core_clk, .rstn, .clk_en, .instr_valid, .instr_word, .instr_ready,
  .unknown_op, .exec_done, .accum, .zero_flag, .busy
);

// ==== sim/and_accum_file_instr_tb.sv ====
// Purpose: Directed bench for the AND-with-file block
// Assumes: Inputs change on the falling edge
// Notes:   clk_en drops once, mid-instruction, in the freeze test
`timescale 1ns/100ps
module and_accum_file_instr_tb;
  reg         core_clk, rstn, clk_en, instr_valid, acc_load, host_wr, host_rd;
  reg  [13:0] instr_word;
  reg  [7:0]  acc_wdata, host_wdata, rd;
  reg  [6:0]  host_addr;
  wire        instr_ready, unknown_op, exec_done, zero_flag, busy;
  wire [7:0]  accum, host_rdata;
  integer     num_errors, tests_run;

  and_accum_file_instr i_dut
  (
    .core_clk, .rstn, .clk_en, .instr_valid, .instr_word, .instr_ready,
    .unknown_op, .exec_done, .accum, .zero_flag, .acc_load, .acc_wdata,
    .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata, .busy
  );

  // 50 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task chk(input string n, input [7:0] s, input [7:0] e);
  begin
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  end
  endtask

  // One-cycle host strobe: 0 loads W, 1 writes file, 2 reads file
  task host(input [1:0] op, input [6:0] a, input [7:0] d);
  begin
    {acc_load, host_wr, host_rd} = {op == 2'h0, op == 2'h1, op == 2'h2};
    {host_addr, acc_wdata, host_wdata} = {a, d, d};
    @(negedge core_clk);
    {acc_load, host_wr, host_rd} = 3'h0;
    rd = host_rdata;
  end
  endtask

  // Offer a word, count cycles to done; a hang ends the run
  task exec(input d, input [6:0] a);
    integer i;
  begin
    {instr_valid, instr_word} = {1'b1, 6'h05, d, a};
    @(negedge core_clk);
    instr_valid = 1'b0;
    i = 1;
    while (exec_done !== 1'b1 && i < 9)
    begin
      @(negedge core_clk);
      i = i + 1;
    end
    if (i == 9)
    begin
      num_errors = num_errors + 1;
      print_verdict;
    end
    chk("cycles", i[7:0], 8'h04);
  end
  endtask

  // Both destinations, then two W runs back to back, incl. a zero result
  task t_dest;
  begin
    host(2'h0, 7'h00, 8'h17);
    host(2'h1, 7'h05, 8'hc2);
    exec(1'b1, 7'h05);
    chk("w kept", accum, 8'h17);
    chk("z clear", zero_flag, 8'h00);
    host(2'h2, 7'h05, 8'h00);
    chk("f result", rd, 8'h02);
    host(2'h0, 7'h00, 8'h5f);
    host(2'h1, 7'h7f, 8'ha3);
    exec(1'b0, 7'h7f);
    chk("w result", accum, 8'h03);
    host(2'h1, 7'h7e, 8'hfc);
    exec(1'b0, 7'h7e);
    exec(1'b0, 7'h7f);
    chk("z set", zero_flag, 8'h01);
    host(2'h2, 7'h7f, 8'h00);
    chk("f kept", rd, 8'ha3);
    $display("test dest done");
  end
  endtask

  // Foreign opcode while idle is dropped, with no state change
  task t_drop;
  begin
    host(2'h0, 7'h00, 8'ha5);
    {instr_valid, instr_word} = {1'b1, 14'h395f};
    @(negedge core_clk);
    instr_valid = 1'b0;
    chk("unknown", unknown_op, 8'h01);
    chk("idle", busy, 8'h00);
    @(negedge core_clk);
    chk("unknown off", unknown_op, 8'h00);
    repeat (3) @(negedge core_clk);
    chk("w same", accum, 8'ha5);
    chk("z same", zero_flag, 8'h01);
    $display("test drop done");
  end
  endtask

  // clk_en low in mid-instruction stretches it and holds all state
  task t_freeze;
  begin
    host(2'h0, 7'h00, 8'hf0);
    host(2'h1, 7'h10, 8'h3c);
    {instr_valid, instr_word} = {1'b1, 6'h05, 1'b0, 7'h10};
    @(negedge core_clk);
    {instr_valid, clk_en} = 2'h0;
    repeat (3) @(negedge core_clk);
    chk("frozen busy", busy, 8'h01);
    chk("frozen done", exec_done, 8'h00);
    chk("frozen w", accum, 8'hf0);
    clk_en = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("late done", exec_done, 8'h01);
    chk("late w", accum, 8'h30);
    chk("late z", zero_flag, 8'h00);
    $display("test freeze done");
  end
  endtask

  initial
  begin
    {rstn, clk_en, instr_valid, acc_load, host_wr, host_rd} = 6'h00;
    {instr_word, acc_wdata, host_wdata, host_addr} = 37'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    clk_en = 1'b1;
    t_dest;
    t_drop;
    t_freeze;
    print_verdict;
  end
endmodule
